// ### src/stop_grant_thermal_trip_ctrl.sv
// Purpose: Stop-grant entry and exit plus latched thermal trip control.
// Assumes: Bus clock clk runs always; core clocks are gated by enables.
// Notes: Bus unit and interrupt unit are gated by this block only on a thermal trip.
`timescale 1ns/1ns
`default_nettype none
module stop_grant_thermal_trip_ctrl
  import stop_trip_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Clock-stop sideband
  input wire logic clock_stop_request_n,
  output logic stop_grant_ack_req,
  input wire logic stop_grant_ack_done,
  output logic stop_grant_active,
  // Core clock gating
  output logic [stop_trip_pkg::CORE_UNITS-1:0] core_clk_en,
  output logic bus_unit_clk_en,
  output logic intr_unit_clk_en,
  output logic exec_enable,
  // Thermal trip
  input wire logic power_good,
  input wire logic sensor_trip,
  output logic thermal_trip_n_out,
  output logic thermal_trip_n_oe,
  // Test access port
  input wire logic test_clk,
  input wire logic test_data_in,
  input wire logic test_shift_en,
  output logic test_data_out
);
  import stop_trip_pkg::*;

  // ---------------------------------------------------------------------------
  // Clock-stop request crossing
  // ---------------------------------------------------------------------------
  logic stop_req_sync_n;
  // Request is asynchronous, so it never reaches logic unsynchronised
  sync_two_stage #(.RESET_VALUE(1'b1)) u_stop_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(clock_stop_request_n),
    .sync_out(stop_req_sync_n)
  ); // see R6

  // ---------------------------------------------------------------------------
  // Stop-grant state machine
  // ---------------------------------------------------------------------------
  stop_state_t state;
  stop_state_t next_state;
  logic stop_req;
  assign stop_req = !stop_req_sync_n;

  // Release during ACK waits for the acknowledge to finish first
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN: if (stop_req) next_state = ST_ACK; // see R1
      ST_ACK: if (stop_grant_ack_done) next_state = stop_req ? ST_STOPPED : ST_RUN;
      ST_STOPPED: if (!stop_req) next_state = ST_RUN; // see R5
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------------------
  // Thermal trip latch
  // ---------------------------------------------------------------------------
  logic [TRIP_CNT_W-1:0] pg_count;
  logic trip_latched;
  logic pg_count_done;
  assign pg_count_done = (pg_count == TRIP_ENABLE_DELAY);

  // Power-good acts as the latch reset; low clears everything at once
  always_ff @(posedge clk)
  begin
    if (!rst_n || !power_good)
    begin
      pg_count <= '0; // see R9
      trip_latched <= 1'b0; // see R10
    end
    else
    begin
      if (!pg_count_done)
        pg_count <= pg_count + TRIP_CNT_W'(1);
      if (sensor_trip)
        trip_latched <= 1'b1; // see R7 R10 R11
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  logic stopped_next;
  logic [CORE_UNITS-1:0] next_core_clk_en;
  logic next_trip_n;
  logic next_trip_oe;
  logic trip_now;
  assign trip_now = trip_latched || (power_good && sensor_trip);
  assign stopped_next = (next_state == ST_STOPPED);
  // A trip halts everything; stop-grant keeps bus and interrupt units
  assign next_core_clk_en = (trip_now || stopped_next) ? CORE_CLK_ALL_OFF : CORE_CLK_ALL_ON;
  // Counter end feeds the output flop directly; one more stage would reach the limit
  assign next_trip_oe = pg_count_done && power_good; // see R8 R9
  assign next_trip_n = !(trip_latched && next_trip_oe);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stop_grant_ack_req <= 1'b0;
      stop_grant_active <= 1'b0;
      core_clk_en <= CORE_CLK_ALL_ON;
      bus_unit_clk_en <= 1'b1;
      intr_unit_clk_en <= 1'b1;
      exec_enable <= 1'b1;
      thermal_trip_n_out <= 1'b1;
      thermal_trip_n_oe <= 1'b0;
    end
    else
    begin
      stop_grant_ack_req <= (next_state == ST_ACK); // see R2
      stop_grant_active <= stopped_next; // see R1
      core_clk_en <= next_core_clk_en; // see R3 R5 R7
      bus_unit_clk_en <= !trip_now; // see R4
      intr_unit_clk_en <= !trip_now; // see R4
      exec_enable <= !(trip_now || stopped_next); // see R5 R7
      thermal_trip_n_out <= next_trip_n; // see R7
      thermal_trip_n_oe <= next_trip_oe; // see R8 R9
    end
  end

  // ---------------------------------------------------------------------------
  // Test access port shift path
  // ---------------------------------------------------------------------------
  // Data path only; the controller state machine lives elsewhere
  logic [TAP_LEN-1:0] tap_shift;
  always_ff @(posedge test_clk)
  begin
    if (!rst_n)
    begin
      tap_shift <= TAP_RESET;
      test_data_out <= 1'b0;
    end
    else if (test_shift_en)
    begin
      tap_shift <= {test_data_in, tap_shift[TAP_LEN-1:1]}; // see R13
      test_data_out <= tap_shift[0]; // see R14
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_trip_latched: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    (power_good && $past(power_good) && $past(!thermal_trip_n_out) && $past(thermal_trip_n_oe))
    |-> !thermal_trip_n_out)
    else $error("Trip output released while power good");
  a_trip_oe_drop: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    !power_good |=> !thermal_trip_n_oe)
    else $error("Trip drive kept after power good low");
  a_trip_oe_rise: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    $rose(power_good) |-> ##[1:99] thermal_trip_n_oe)
    else $error("Trip drive not enabled in time");
  a_trip_rearm: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    ($rose(power_good) && sensor_trip) ##1 (power_good && sensor_trip)[*8]
    |-> ##[0:91] !thermal_trip_n_out)
    else $error("Trip not reasserted after power good");
  a_trip_halts: assert property (@(posedge clk) disable iff (!rst_n) // see R7
    (power_good && sensor_trip) |=> (core_clk_en == CORE_CLK_ALL_OFF) && !exec_enable)
    else $error("Clocks run during thermal trip");
  a_stop_ack: assert property (@(posedge clk) disable iff (!rst_n) // see R2
    $rose(stop_grant_active) |-> $past(stop_grant_ack_req))
    else $error("Stop grant without acknowledge");
  a_stop_gating: assert property (@(posedge clk) disable iff (!rst_n) // see R3 R4
    (stop_grant_active && !trip_now && $past(!trip_now))
    |-> (core_clk_en == CORE_CLK_ALL_OFF) && bus_unit_clk_en && intr_unit_clk_en)
    else $error("Wrong clock gating in stop grant");
  a_stop_enter: assert property (@(posedge clk) disable iff (!rst_n) // see R1 R16
    ($fell(clock_stop_request_n) && state == ST_RUN) |-> ##3 stop_grant_ack_req)
    else $error("Stop request not acted on in three cycles");
  a_stop_exit: assert property (@(posedge clk) disable iff (!rst_n) // see R5
    (state == ST_STOPPED && stop_req_sync_n && !trip_now) |=> exec_enable)
    else $error("Execution not resumed after release");
  // Acknowledge request stands until the system reports it done
  a_ack_held: assert property (@(posedge clk) disable iff (!rst_n) // see R2
    (stop_grant_ack_req && !stop_grant_ack_done) |=> stop_grant_ack_req)
    else $error("Acknowledge request dropped early");
  // A new acknowledge only ever starts from the running state
  a_ack_from_run: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    $rose(stop_grant_ack_req) |-> $past(state == ST_RUN))
    else $error("Acknowledge started outside run state");
  // Dropping power good releases a latched trip on the next edge
  a_trip_cleared: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    !power_good |=> thermal_trip_n_out)
    else $error("Trip output held after power good low");
  // With power good low for two edges the pin stays undriven
  a_trip_off_low: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    (!power_good && !$past(power_good)) |-> !thermal_trip_n_oe && thermal_trip_n_out)
    else $error("Trip driven while power good low");
  // Stop-grant never lets execution run
  a_exec_stopped: assert property (@(posedge clk) disable iff (!rst_n) // see R1 R5
    stop_grant_active |-> !exec_enable)
    else $error("Execution running in stop grant");
  // Bus and interrupt units keep their clocks unless a trip is in force
  a_bus_clk_run: assert property (@(posedge clk) disable iff (!rst_n) // see R4 R6
    (!trip_now && !$past(trip_now)) |-> bus_unit_clk_en && intr_unit_clk_en)
    else $error("Bus or interrupt clock gated without trip");
  // Shift path hands its low bit to the serial output each shift
  a_tap_shift_out: assert property (@(posedge test_clk) disable iff (!rst_n) // see R14
    test_shift_en |=> (test_data_out == $past(tap_shift[0])))
    else $error("Serial output not the shifted bit");
endmodule : stop_grant_thermal_trip_ctrl
`default_nettype wire

// ### src/stop_trip_pkg.sv
// Purpose: Constants for the clock-stop and thermal-trip sideband controller.
// Assumes: One 10 MHz clock; synchronous active-low reset.
// Notes: Every constant of the block is named once here.
// Operation
// R1: Clock-stop request enters low-power stop-grant state
// R2: Entering stop-grant issues acknowledge bus transaction
// R3: Gate core clocks except bus, interrupt units
// R4: Keep snooping and servicing interrupts while stopped
// R5: Request release restarts clocks, resumes execution
// R6: Request asynchronous; bus clock never affected
// R7: Trip temperature asserts trip output, stops clocks
// R8: Trip driving enabled within 10 us of power-good
// R9: Trip driving disabled when power-good drops
// R10: Trip stays latched until power-good drops
// R11: Still hot at power-good: retrip within 10 us
// R12: System removes core supply after trip asserts
// R13: Test data shifts in on input, test clock
// R14: Test data shifts out on output pin
// R15: System keeps power-good clean and monotonic
// R16: Clock-stop request passes two-stage synchroniser
package stop_trip_pkg;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TRIP_ENABLE_US = 10;
  // Longest time rounds down
  localparam int TRIP_ENABLE_CYCLES = (TRIP_ENABLE_US * 1000) / CLK_PERIOD_NS;
  localparam int TRIP_CNT_W = 7;
  // Delay used for enable: two cycles under the limit
  localparam logic [TRIP_CNT_W-1:0] TRIP_ENABLE_DELAY = TRIP_CNT_W'(TRIP_ENABLE_CYCLES - 2);
  // ---------------------------------------------------------------------------
  // Core units and reset values
  // ---------------------------------------------------------------------------
  localparam int CORE_UNITS = 4;
  localparam logic [CORE_UNITS-1:0] CORE_CLK_ALL_ON = 4'hf;
  localparam logic [CORE_UNITS-1:0] CORE_CLK_ALL_OFF = 4'h0;
  localparam int TAP_LEN = 8;
  localparam logic [TAP_LEN-1:0] TAP_RESET = 8'h00;
  typedef enum logic [1:0] {ST_RUN, ST_ACK, ST_STOPPED} stop_state_t;
endpackage : stop_trip_pkg

// ### src/sync_two_stage.sv
// Purpose: Two flip-flop level synchroniser.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module sync_two_stage #(
  parameter logic RESET_VALUE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  // Metastability guard; two edges of latency traded for safety
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      stage1 <= async_in; // see R16
      sync_out <= stage1; // see R16
    end
  end
endmodule : sync_two_stage
`default_nettype wire

// ### tb/system_side_model.sv
// Purpose: System board logic facing the stop-grant and thermal-trip controller.
// Assumes: Everything moves on clk; the bench gives plain commands.
// Notes: Acknowledge latency set by ack_delay, so slow answers can be tried.
`timescale 1ns/1ns
`default_nettype none
module system_side_model (
  // Clock and bench commands
  input wire logic clk,
  input wire logic stop_cmd,
  input wire logic pg_cmd,
  input wire logic [7:0] ack_delay,
  // Controller side
  input wire logic stop_grant_ack_req,
  input wire logic thermal_trip_n_out,
  input wire logic thermal_trip_n_oe,
  output logic clock_stop_request_n,
  output logic stop_grant_ack_done,
  output logic power_good,
  output logic core_supply_on
);
  logic [7:0] wait_cnt;
  initial
  begin
    {clock_stop_request_n, stop_grant_ack_done, power_good, core_supply_on} = 4'h9;
    wait_cnt = 8'h00;
  end
  // Answer the acknowledge after ack_delay cycles; registered so power good never glitches
  always @(posedge clk)
  begin
    wait_cnt <= stop_grant_ack_req ? wait_cnt + 8'h01 : 8'h00;
    stop_grant_ack_done <= stop_grant_ack_req && (wait_cnt == ack_delay);
    clock_stop_request_n <= !stop_cmd;
    power_good <= pg_cmd;
    if (thermal_trip_n_oe && !thermal_trip_n_out) core_supply_on <= 1'b0;
    else if (!pg_cmd) core_supply_on <= 1'b1;
  end
endmodule : system_side_model
`default_nettype wire

// ### tb/stop_grant_thermal_trip_ctrl_tb.sv
// Purpose: Self-checking bench for the stop-grant and thermal-trip controller.
// Assumes: 10 MHz clk, free-running unrelated test clock.
// Notes: Trip halts all clocks, so it runs after the stop-grant tests.
`timescale 1ns/1ns
`default_nettype none
module stop_grant_thermal_trip_ctrl_tb;
  import stop_trip_pkg::*;
  logic clk = 0, rst_n = 0, stop_cmd = 0, pg_cmd = 0, sensor_trip = 0;
  logic test_clk = 0, test_data_in = 0, test_shift_en = 0;
  logic [7:0] ack_delay = 8'h00;
  wire logic req_n, ack_req, ack_done, active, bus_en, intr_en, exec_en, pg, supply_on;
  wire logic trip_n, trip_oe, tdo;
  wire logic [CORE_UNITS-1:0] core_en;
  int n_mismatch = 0, n_compared = 0, n;
  logic [23:0] pat = 24'h5ac396;
  initial forever #50 clk = !clk;
  initial forever #37 test_clk = !test_clk;
  stop_grant_thermal_trip_ctrl dut (.clk(clk), .rst_n(rst_n), .clock_stop_request_n(req_n),
    .stop_grant_ack_req(ack_req), .stop_grant_ack_done(ack_done), .stop_grant_active(active),
    .core_clk_en(core_en), .bus_unit_clk_en(bus_en), .intr_unit_clk_en(intr_en),
    .exec_enable(exec_en), .power_good(pg), .sensor_trip(sensor_trip),
    .thermal_trip_n_out(trip_n), .thermal_trip_n_oe(trip_oe), .test_clk(test_clk),
    .test_data_in(test_data_in), .test_shift_en(test_shift_en), .test_data_out(tdo));
  system_side_model far (.clk(clk), .stop_cmd(stop_cmd), .pg_cmd(pg_cmd),
    .ack_delay(ack_delay), .stop_grant_ack_req(ack_req), .thermal_trip_n_out(trip_n),
    .thermal_trip_n_oe(trip_oe), .clock_stop_request_n(req_n),
    .stop_grant_ack_done(ack_done), .power_good(pg), .core_supply_on(supply_on));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  // Stop-grant entry and exit; a slow acknowledge lets release land mid-handshake
  task automatic stop_grant(input logic [7:0] dly, input logic early_release);
    @(posedge clk) ack_delay <= dly;
    stop_cmd <= 1'b1;
    tick(3);
    check("ack before sync", ack_req, 1'b0);
    for (n = 0; n < 10 && ack_req !== 1'b1; n++) tick(1);
    check("ack request", ack_req, 1'b1);
    if (early_release) stop_cmd <= 1'b0;
    for (n = 0; n < 40 && ack_req !== 1'b0; n++) tick(1);
    tick(1);
    check("stopped", active, !early_release);
    check("core clocks", core_en, early_release ? CORE_CLK_ALL_ON : CORE_CLK_ALL_OFF);
    check("bus intr clocks", {bus_en, intr_en}, 2'h3);
    @(posedge clk) stop_cmd <= 1'b0;
    for (n = 0; n < 10 && exec_en !== 1'b1; n++) tick(1);
    check("resumed", {active, exec_en, core_en}, {2'h1, CORE_CLK_ALL_ON});
    $display("test stop_grant done");
  endtask : stop_grant
  // Wait for trip driving after power good, counting cycles against 10 us
  task automatic wait_oe;
    @(posedge clk) pg_cmd <= 1'b1;
    for (n = 0; n < 200 && trip_oe !== 1'b1; n++) tick(1);
    check("enable in time", n <= TRIP_ENABLE_CYCLES, 1'b1);
  endtask : wait_oe
  task automatic trip;
    wait_oe();
    @(posedge clk) sensor_trip <= 1'b1;
    tick(2);
    check("trip out", {trip_n, exec_en, core_en}, {2'h0, CORE_CLK_ALL_OFF});
    check("trip bus intr clocks", {bus_en, intr_en}, 2'h0);
    @(posedge clk) sensor_trip <= 1'b0;
    tick(8);
    check("latched", {trip_n, supply_on}, 2'h0);
    @(posedge clk) pg_cmd <= 1'b0;
    sensor_trip <= 1'b1;
    tick(3);
    check("released", {trip_oe, trip_n}, 2'h1);
    wait_oe();
    tick(2);
    check("trip again", trip_n, 1'b0);
    $display("test trip done");
  endtask : trip
  // Serial path: each bit reappears on test data out nine test clocks later
  task automatic tap_shift;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge test_clk) test_shift_en <= 1'b1;
      test_data_in <= pat[i];
      @(negedge test_clk);
      if (i >= 9) check("test data out", tdo, pat[i-9]);
    end
    $display("test tap_shift done");
  endtask : tap_shift
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    tick(15);
    check("reset values", {ack_req, active, exec_en, trip_oe}, 4'h2);
    @(posedge clk) rst_n <= 1'b1;
    tick(2);
    stop_grant(8'h00, 1'b0);
    stop_grant(8'h14, 1'b1);
    stop_grant(8'h05, 1'b0);
    tap_shift();
    trip();
    close_out();
  end
  initial
  begin
    // About six times the expected run time
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule : stop_grant_thermal_trip_ctrl_tb
`default_nettype wire
